/* File: bench/rtm_pin_model.sv */
// Purpose: far-side pins: timer input and comparator output
// Assumes: bench asks for levels
// Notes: moves by nba on the rising edge, so bench levels set at the
// falling edge are taken without a race and the sync flops see one change
`timescale 1ns/1ps
module rtm_pin_model (
    input wire logic sys_clk, // clock
    input wire logic want_in, // level asked of the input pin
    input wire logic want_cmp, // level asked of the comparator
    output logic timer_in = 1'b0, // to timer input
    output logic comparator_out = 1'b0 // to comparator input
);
    always @(posedge sys_clk) begin
        timer_in <= want_in;
        comparator_out <= want_cmp;
    end
endmodule : rtm_pin_model

/* File: bench/rtm_timer_chk.sv */
// Purpose: port-level assertions for rtm_timer
// Assumes: sees only top ports; bound from the bench top
// Notes: single clock domain, so default clocking is used
`timescale 1ns/1ps
`include "rtm_timer_regs.svh"
module rtm_timer_chk (
    input wire logic sys_clk, // clock
    input wire logic reset, // sync reset
    input wire logic enable, // timer enable
    input wire logic [`RTM_MODE_W-1:0] mode, // mode
    input wire logic output_polarity_bit, // polarity
    input wire logic [`RTM_CFG_W-1:0] interrupt_source_config, // irq source
    input wire logic output_alt_enable, // alt function
    input wire logic timer_output_pin, // output
    input wire logic timer_output_comp, // complement
    input wire logic timer_irq, // irq pulse
    input wire logic capture_cause_flag, // capture flag
    input wire logic [`RTM_CNT_W-1:0] capture_value, // capture
    input wire logic timer_running // running
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////
    sequence alt_off2;
        !output_alt_enable ##1 !output_alt_enable;
    endsequence
    // eight idle cycles cover the deadband pipeline
    sequence pwm_idle8;
        (mode == `RTM_MODE_PWMDUAL && !enable && output_alt_enable
            && $stable(output_polarity_bit))[*8];
    endsequence
    sequence pwm_settled;
        mode == `RTM_MODE_PWMDUAL && $past(mode, 2) == `RTM_MODE_PWMDUAL
            && $past(output_polarity_bit, 2) == output_polarity_bit
            && output_alt_enable && $past(output_alt_enable, 2);
    endsequence
    irq_one_cycle_a: assert property (timer_irq |=> !timer_irq)
        else $error("irq pulse longer than one cycle");
    alt_off_low_a: assert property (alt_off2 |-> !timer_output_pin && !timer_output_comp)
        else $error("output driven with alternate function off");
    cont_toggle_a: assert property (timer_irq && mode == `RTM_MODE_CONT && $stable(mode)
        && output_alt_enable && $past(output_alt_enable) |-> $changed(timer_output_pin))
        else $error("no output toggle at reload");
    oneshot_stop_a: assert property (timer_irq && mode == `RTM_MODE_ONESHOT
        |-> ##[0:1] !timer_running)
        else $error("one-shot kept running");
    pwm_idle_a: assert property (pwm_idle8 |-> timer_output_pin == output_polarity_bit
        && timer_output_comp == !output_polarity_bit)
        else $error("idle dual output levels wrong");
    pwm_overlap_a: assert property (pwm_settled |-> !(timer_output_pin != output_polarity_bit
        && timer_output_comp != output_polarity_bit))
        else $error("both outputs asserted together");
    cap_flag_a: assert property ($changed(capture_value) && mode == `RTM_MODE_CAPCMP
        && $stable(mode) && interrupt_source_config != `RTM_CFG_RELOAD_ONLY
        |-> timer_irq && capture_cause_flag)
        else $error("capture without irq and flag");
    cfg_reload_a: assert property (timer_irq && mode == `RTM_MODE_CAPCMP
        && interrupt_source_config == `RTM_CFG_RELOAD_ONLY |-> !capture_cause_flag)
        else $error("capture irq under reload-only");
    cfg_event_a: assert property (timer_irq && mode == `RTM_MODE_CAPCMP
        && interrupt_source_config == `RTM_CFG_EVENT_ONLY |-> capture_cause_flag)
        else $error("reload irq under event-only");
endmodule : rtm_timer_chk

/* File: bench/rtm_timer_tb.sv */
// Purpose: self-checking bench for rtm_timer
// Assumes: inputs move on the falling edge
// Notes: random reloads from a fixed seed
`timescale 1ns/1ps
`include "rtm_timer_regs.svh"
module rtm_timer_tb;
    logic sys_clk = 1'b0, reset = 1'b1, enable = 1'b0, output_polarity_bit = 1'b0;
    logic [3:0] mode = 4'h0;
    logic [2:0] prescale = 3'h0, deadband_delay_field = 3'h0;
    logic [1:0] interrupt_source_config = 2'h0;
    logic [15:0] reload_value = 16'h0000, pwm_value = 16'h0000, count_write_data = 16'h0000;
    logic count_write = 1'b0, read_count_high = 1'b0, read_count_low = 1'b0;
    logic output_alt_enable = 1'b0, want_in = 1'b0, want_cmp = 1'b0;
    logic timer_in, comparator_out, timer_output_pin, timer_output_comp, timer_irq;
    logic capture_cause_flag, timer_running, v;
    logic [15:0] capture_value, rv;
    logic [7:0] read_data, b0, b1;
    int err_count = 0, compares = 0, seed = 32, n;
    always #25 sys_clk = ~sys_clk;
    rtm_pin_model u_pins (.sys_clk, .want_in, .want_cmp, .timer_in, .comparator_out);
    rtm_timer u_dut (.sys_clk, .reset, .enable, .mode, .prescale, .output_polarity_bit,
        .interrupt_source_config, .deadband_delay_field, .reload_value, .pwm_value,
        .count_write, .count_write_data, .read_count_high, .read_count_low,
        .output_alt_enable, .timer_in, .comparator_out, .timer_output_pin,
        .timer_output_comp, .timer_irq, .capture_cause_flag, .capture_value,
        .read_data, .timer_running);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] exp_period(input logic [15:0] rl, input int p);
        return rl << p;
    endfunction : exp_period
    task automatic cyc(input int k);
        repeat (k) @(negedge sys_clk);
    endtask : cyc
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_irq(input int lim, output int c);
        c = 0;
        while (timer_irq !== 1'b1 && c < lim) begin
            cyc(1);
            c++;
        end
    endtask : wait_irq
    task automatic setup(input logic [3:0] m, input logic [2:0] p, input logic [15:0] rl,
        input logic [15:0] st, input logic po, input logic [1:0] c);
        enable = 1'b0;
        mode = m;
        prescale = p;
        output_polarity_bit = po;
        count_write_data = st;
        count_write = 1'b1;
        cyc(1);
        count_write = 1'b0;
        reload_value = rl;
        interrupt_source_config = c;
        cyc(2);
    endtask : setup
    task automatic rd(input logic hi, output logic [7:0] d);
        read_count_high = hi;
        read_count_low = ~hi;
        cyc(1);
        read_count_high = 1'b0;
        read_count_low = 1'b0;
        cyc(1);
        d = read_data;
    endtask : rd
    task automatic print_verdict();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict
    initial begin
        cyc(60000);
        err_count++;
        print_verdict();
    end
    initial begin
        cyc(5);
        reset = 1'b0;
        cyc(3);
        output_alt_enable = 1'b1;
        for (int p = 0; p < 8; p++) begin
            rv = 16'h0004 + 16'($random(seed) & 7);
            setup(`RTM_MODE_CONT, 3'(p), rv, 16'h0001, 1'b0, 2'h0);
            enable = 1'b1;
            wait_irq(4000, n);
            v = timer_output_pin;
            cyc(1);
            wait_irq(4000, n);
            chk(16'(n + 1), exp_period(rv, p));
            chk(16'(timer_output_pin), 16'(!v));
        end
        $display("test continuous done");
        setup(`RTM_MODE_ONESHOT, 3'h0, 16'h0008, 16'h0001, 1'b0, 2'h0);
        enable = 1'b1;
        cyc(1);
        // flip after the start edge: a level change at timeout, not a pulse
        output_polarity_bit = 1'b1;
        cyc(2);
        chk(16'(timer_output_pin), 16'h0000);
        wait_irq(100, n);
        cyc(2);
        chk(16'(timer_running), 16'h0000);
        chk(16'(timer_output_pin), 16'h0001);
        wait_irq(50, n);
        chk(16'(n), 16'h0032);
        $display("test one-shot done");
        rv = 16'($random(seed));
        setup(`RTM_MODE_CONT, 3'h0, 16'hffff, rv, 1'b0, 2'h0);
        rd(1'b1, b0);
        chk(16'(b0), 16'(rv[15:8]));
        rd(1'b0, b0);
        chk(16'(b0), 16'(rv[7:0]));
        enable = 1'b1;
        cyc(3);
        rd(1'b1, b0);
        cyc(5);
        rd(1'b0, b0);
        cyc(5);
        rd(1'b0, b1);
        chk(16'(b1), 16'(b0));
        $display("test reads done");
        // k picks the edge and the irq source: both, reload only, event only
        for (int k = 0; k < 6; k++) begin
            want_in = k[0];
            setup(`RTM_MODE_CAPCMP, 3'h0, 16'h003c, 16'h0001, k[0], {k[2] | k[1], k[1]});
            enable = 1'b1;
            cyc(5);
            want_in = ~want_in;
            wait_irq(20, n);
            chk(16'(n), 16'h0014);
            want_in = ~want_in;
            cyc(10);
            want_in = ~want_in;
            wait_irq(10, n);
            chk(16'(n < 10), 16'(!k[1]));
            if (!k[1]) chk(16'(capture_cause_flag), 16'h0001);
            cyc(1);
            wait_irq(100, n);
            chk(16'({n < 100, capture_cause_flag}), 16'({!k[2], 1'b0}));
        end
        $display("test capture done");
        for (int k = 0; k < 2; k++) begin
            setup(`RTM_MODE_PWMDUAL, 3'h0, 16'h000c, 16'h0001, k[0], 2'h0);
            deadband_delay_field = 3'h2;
            pwm_value = 16'h0005;
            cyc(10);
            chk(16'({timer_output_pin, timer_output_comp}), 16'({k[0], ~k[0]}));
            enable = 1'b1;
            n = 0;
            repeat (24) begin
                cyc(1);
                n += (timer_output_pin != k[0]);
            end
            chk(16'(n >= 2 && n <= 14), 16'h0001);
        end
        $display("test pwm done");
        setup(`RTM_MODE_GATED, 3'h0, 16'h03e8, 16'h0001, 1'b0, `RTM_CFG_EVENT_ONLY);
        want_in = 1'b0;
        enable = 1'b1;
        cyc(5);
        want_in = 1'b1;
        cyc(20);
        want_in = 1'b0;
        wait_irq(10, n);
        chk(16'(n < 10), 16'h0001);
        $display("test gated done");
        want_in = 1'b1;
        setup(`RTM_MODE_CAPRST, 3'h0, 16'h003c, 16'h0001, 1'b1, 2'h0);
        enable = 1'b1;
        cyc(5);
        want_in = 1'b0;
        wait_irq(10, n);
        chk(16'(n < 10), 16'h0001);
        // start count 1, one step a cycle, three cycles of input sync
        chk(capture_value, 16'h0008);
        want_in = 1'b1;
        cyc(1);
        wait_irq(10, n);
        chk(16'(n), 16'h000a);
        $display("test capture restart done");
        setup(`RTM_MODE_CMPCNT, 3'h0, 16'h0003, 16'h0001, 1'b1, 2'h0);
        cyc(5);
        chk(16'(timer_output_pin), 16'h0001);
        enable = 1'b1;
        n = 0;
        repeat (16) begin
            v = timer_output_pin;
            want_cmp = ~want_cmp;
            cyc(4);
            n += (timer_output_pin != v);
        end
        chk(16'(n > 0), 16'h0001);
        $display("test comparator done");
        print_verdict();
    end
endmodule : rtm_timer_tb
bind rtm_timer rtm_timer_chk u_chk (.sys_clk, .reset, .enable, .mode, .output_polarity_bit,
    .interrupt_source_config, .output_alt_enable, .timer_output_pin, .timer_output_comp,
    .timer_irq, .capture_cause_flag, .capture_value, .timer_running);

/* File: src/rtm_timer.sv */
// Purpose: 16-bit reloadable timer with prescaler and several modes
// Assumes: control bits are plain ports written by local software
// Notes: timer_in and comparator_out are synchronised before use
`timescale 1ns/1ps
`include "rtm_timer_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - one-shot counts prescaled system clock only
// - continuous counts to reload, restarts at 0001H
// - output inverts on every reload
// - gated start count only first pass
// - gated polarity picks active level, edge
// - gated interrupts selectable deassert or reload
// - capture/compare first edge starts, no interrupt
// - later edges capture, interrupt, flag, restart
// - compare reached: interrupt, clear flag, restart
// - capture/compare interrupts selectable by config
// - high read latches low byte while enabled
// - low read when disabled gives live count
// - dual pwm polarity 0 output levels
// - dual pwm polarity 1 output levels
// - deadband delays asserting edge of outputs
// - capture restart edge chosen by polarity
// - comparator counter edges, output hold, toggle
// - pin follows polarity, changes not immediate
// - prescale divides by 1 to 128
module rtm_timer (
    input wire logic sys_clk, // 20 MHz system clock
    input wire logic reset, // synchronous, active high
    input wire logic enable, // timer enable from software
    input wire logic [`RTM_MODE_W-1:0] mode, // operating mode
    input wire logic [2:0] prescale, // divide by 2**prescale
    input wire logic output_polarity_bit, // polarity / edge select
    input wire logic [`RTM_CFG_W-1:0] interrupt_source_config, // irq source select
    input wire logic [`RTM_DB_W-1:0] deadband_delay_field, // dual pwm deadband
    input wire logic [`RTM_CNT_W-1:0] reload_value, // reload / compare value
    input wire logic [`RTM_CNT_W-1:0] pwm_value, // pwm match value
    input wire logic count_write, // pulse: load start count
    input wire logic [`RTM_CNT_W-1:0] count_write_data, // start count
    input wire logic read_count_high, // pulse: read count high byte
    input wire logic read_count_low, // pulse: read count low byte
    input wire logic output_alt_enable, // output alternate function on
    input wire logic timer_in, // timer input pin, async
    input wire logic comparator_out, // comparator output, async
    output logic timer_output_pin, // timer output
    output logic timer_output_comp, // timer output complement
    output logic timer_irq, // one-cycle interrupt pulse
    output logic capture_cause_flag, // set by a capture, cleared by a capture-mode reload
    output logic [`RTM_CNT_W-1:0] capture_value, // captured count
    output logic [7:0] read_data, // byte returned by a read
    output logic timer_running // counter is active
);

    rtm_timer_pkg::rtm_state_s cur;
    rtm_timer_pkg::rtm_state_s nxt;

    logic [`RTM_PRE_W-1:0] presc_max;
    logic tick;
    logic in_rise;
    logic in_fall;
    logic sel_edge;
    logic cmp_edge;
    logic at_reload;
    logic reload_ev;
    logic capture_ev;
    logic deassert_ev;
    logic en_rise;
    logic cfg_allow_ev;
    logic cfg_allow_rl;
    logic gate_active;

    ////////////////////////////////////////////////////////////////////////////
    // shared decodes from the registered state
    always_comb begin
        presc_max = (`RTM_PRE_ONE << prescale) - `RTM_PRE_ONE;
        tick = (cur.presc == presc_max);
        in_rise = cur.in_s2 & ~cur.in_prev;
        in_fall = ~cur.in_s2 & cur.in_prev;
        sel_edge = output_polarity_bit ? in_fall : in_rise;
        cmp_edge = output_polarity_bit ? (~cur.cmp_s2 & cur.cmp_prev)
                                       : (cur.cmp_s2 & ~cur.cmp_prev);
        at_reload = (cur.count == reload_value);
        en_rise = enable & ~cur.en_prev;
        gate_active = (cur.in_s2 != output_polarity_bit);
        cfg_allow_ev = (interrupt_source_config != `RTM_CFG_RELOAD_ONLY);
        cfg_allow_rl = (interrupt_source_config != `RTM_CFG_EVENT_ONLY);
    end

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        nxt = cur;
        reload_ev = 1'b0;
        capture_ev = 1'b0;
        deassert_ev = 1'b0;
        nxt.in_s1 = timer_in;
        nxt.in_s2 = cur.in_s1;
        nxt.in_prev = cur.in_s2;
        nxt.cmp_s1 = comparator_out;
        nxt.cmp_s2 = cur.cmp_s1;
        nxt.cmp_prev = cur.cmp_s2;
        nxt.en_prev = enable;
        nxt.irq = 1'b0;

        if (count_write) begin
            nxt.count = count_write_data;
            nxt.first_done = 1'b0;
        end

        if (!enable) begin
            // self-stopped one-shot holds RTM_IDLE in the case default until software drops enable
            nxt.st = rtm_timer_pkg::RTM_IDLE;
            nxt.presc = `RTM_PRE_ZERO;
            nxt.db_cnt = `RTM_DB_ZERO;
            nxt.db_out = 1'b0;
            nxt.db_comp = 1'b0;
            nxt.out = output_polarity_bit;
            nxt.comp = ~output_polarity_bit;
        end else if (en_rise) begin
            // polarity is taken once here, later changes wait for enable to drop, or in dual pwm for a reload or match
            nxt.out = output_polarity_bit;
            nxt.comp = ~output_polarity_bit;
            nxt.presc = `RTM_PRE_ZERO;
            if (mode == `RTM_MODE_CAPCMP) begin
                nxt.st = rtm_timer_pkg::RTM_ARMED;
            end else begin
                nxt.st = rtm_timer_pkg::RTM_RUN;
            end
        end else begin
            case (cur.st)
                rtm_timer_pkg::RTM_ARMED: begin
                    if (sel_edge) begin
                        nxt.st = rtm_timer_pkg::RTM_RUN;
                    end
                end
                rtm_timer_pkg::RTM_RUN: begin
                    case (mode)
                        `RTM_MODE_GATED: begin
                            if (gate_active) begin
                                nxt.presc = tick ? `RTM_PRE_ZERO
                                                 : cur.presc + `RTM_PRE_ONE;
                                reload_ev = tick & at_reload;
                            end
                            deassert_ev = output_polarity_bit ? in_rise
                                                              : in_fall;
                        end
                        `RTM_MODE_CAPCMP, `RTM_MODE_CAPRST: begin
                            nxt.presc = tick ? `RTM_PRE_ZERO
                                             : cur.presc + `RTM_PRE_ONE;
                            capture_ev = sel_edge;
                            reload_ev = ~sel_edge & tick & at_reload;
                        end
                        `RTM_MODE_CMPCNT: begin
                            capture_ev = 1'b0;
                            reload_ev = cmp_edge & at_reload;
                        end
                        default: begin
                            // one-shot, continuous and pwm use the system clock
                            nxt.presc = tick ? `RTM_PRE_ZERO
                                             : cur.presc + `RTM_PRE_ONE;
                            reload_ev = tick & at_reload;
                        end
                    endcase

                    // counting
                    if (capture_ev) begin
                        nxt.cap = cur.count;
                        nxt.cause = 1'b1;
                        nxt.count = `RTM_CNT_RESTART;
                        nxt.irq = cfg_allow_ev;
                    end else if (reload_ev) begin
                        nxt.count = `RTM_CNT_RESTART;
                        nxt.first_done = 1'b1;
                        if (mode == `RTM_MODE_CAPCMP || mode == `RTM_MODE_CAPRST) begin
                            nxt.cause = 1'b0;
                        end
                        if (mode == `RTM_MODE_GATED || mode == `RTM_MODE_CAPCMP) begin
                            nxt.irq = cfg_allow_rl;
                        end else begin
                            nxt.irq = 1'b1;
                        end
                        if (mode == `RTM_MODE_ONESHOT) begin
                            nxt.st = rtm_timer_pkg::RTM_IDLE;
                        end
                    end else if (deassert_ev) begin
                        // gated: a deassertion resets the count to 0001H
                        nxt.count = `RTM_CNT_RESTART;
                        nxt.first_done = 1'b1;
                        nxt.irq = cfg_allow_ev;
                    end else if (mode == `RTM_MODE_CMPCNT) begin
                        if (cmp_edge) begin
                            nxt.count = cur.count + `RTM_CNT_RESTART;
                        end
                    end else if (mode == `RTM_MODE_GATED) begin
                        if (gate_active && tick) begin
                            nxt.count = cur.count + `RTM_CNT_RESTART;
                        end
                    end else if (tick) begin
                        nxt.count = cur.count + `RTM_CNT_RESTART;
                    end

                    // output levels
                    if (mode == `RTM_MODE_PWMDUAL) begin
                        if (reload_ev) begin
                            // deasserted edge at once, asserted edge after deadband
                            nxt.out = output_polarity_bit;
                            nxt.db_comp = 1'b1;
                            nxt.db_out = 1'b0;
                            nxt.db_cnt = deadband_delay_field;
                        end else if (tick && cur.count == pwm_value) begin
                            nxt.comp = output_polarity_bit;
                            nxt.db_out = 1'b1;
                            nxt.db_comp = 1'b0;
                            nxt.db_cnt = deadband_delay_field;
                        end else if (cur.db_cnt != `RTM_DB_ZERO) begin
                            nxt.db_cnt = cur.db_cnt - 3'h1;
                        end else begin
                            if (cur.db_out) begin
                                nxt.out = ~output_polarity_bit;
                                nxt.db_out = 1'b0;
                            end
                            if (cur.db_comp) begin
                                nxt.comp = ~output_polarity_bit;
                                nxt.db_comp = 1'b0;
                            end
                        end
                    end else if (reload_ev) begin
                        nxt.out = ~cur.out;
                    end
                end
                default: begin
                    nxt.st = cur.st;
                end
            endcase
        end

        // count reads never touch the counter itself
        if (read_count_high) begin
            nxt.rdata = cur.count[`RTM_CNT_W-1:`RTM_CNT_W/2];
            if (enable) begin
                nxt.hold = cur.count[`RTM_CNT_W/2-1:0];
            end
        end else if (read_count_low) begin
            nxt.rdata = enable ? cur.hold : cur.count[`RTM_CNT_W/2-1:0];
        end

        nxt.pin = output_alt_enable ? nxt.out : 1'b0;
        nxt.pin_n = output_alt_enable ? nxt.comp : 1'b0;
        nxt.running = (nxt.st == rtm_timer_pkg::RTM_RUN);
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cur <= '0;
        end else begin
            cur <= nxt;
        end
    end

    always_comb begin
        timer_output_pin = cur.pin;
        timer_output_comp = cur.pin_n;
        timer_irq = cur.irq;
        capture_cause_flag = cur.cause;
        capture_value = cur.cap;
        read_data = cur.rdata;
        timer_running = cur.running;
    end

endmodule : rtm_timer

/* File: src/rtm_timer_pkg.sv */
// Purpose: types for the reloadable timer
// Assumes: rtm_timer_regs.svh holds the numbers
// Notes: whole module state lives in one struct
`include "rtm_timer_regs.svh"
package rtm_timer_pkg;
    typedef enum logic [1:0] {
        RTM_IDLE = 2'b00,
        RTM_ARMED = 2'b01,
        RTM_RUN = 2'b11
    } rtm_state_e;

    typedef struct packed {
        rtm_state_e st;
        logic in_s1;
        logic in_s2;
        logic in_prev;
        logic cmp_s1;
        logic cmp_s2;
        logic cmp_prev;
        logic en_prev;
        logic first_done;
        logic [`RTM_CNT_W-1:0] count;
        logic [`RTM_PRE_W-1:0] presc;
        logic [7:0] hold;
        logic out;
        logic comp;
        logic [`RTM_DB_W-1:0] db_cnt;
        logic db_out;
        logic db_comp;
        logic pin;
        logic pin_n;
        logic irq;
        logic cause;
        logic [`RTM_CNT_W-1:0] cap;
        logic [7:0] rdata;
        logic running;
    } rtm_state_s;
endpackage : rtm_timer_pkg

/* File: src/rtm_timer_regs.svh */
// Purpose: constants for the reloadable timer
// Assumes: included by bare name
// Notes: mode codes are local choices
`ifndef RTM_TIMER_REGS_SVH
`define RTM_TIMER_REGS_SVH
`define RTM_CNT_W 16
`define RTM_PRE_W 8
`define RTM_DB_W 3
`define RTM_MODE_W 4
`define RTM_CNT_RESTART 16'h0001
`define RTM_CNT_ZERO 16'h0000
`define RTM_PRE_ONE 8'h01
`define RTM_PRE_ZERO 8'h00
`define RTM_DB_ZERO 3'h0
`define RTM_BYTE_ZERO 8'h00
`define RTM_MODE_ONESHOT 4'h0
`define RTM_MODE_CONT 4'h1
`define RTM_MODE_GATED 4'h6
`define RTM_MODE_CAPCMP 4'h7
`define RTM_MODE_CAPRST 4'h8
`define RTM_MODE_CMPCNT 4'h9
`define RTM_MODE_PWMDUAL 4'ha
`define RTM_CFG_W 2
`define RTM_CFG_EVENT_ONLY 2'h2
`define RTM_CFG_RELOAD_ONLY 2'h3
`endif
